// >>> olr_pkg.sv
/*
 * Package for the reverse-output current limit and input-voltage
 * threshold register pair: byte addresses, field layout, reset values.
 * Assumes a byte-wide register port decoded by the serial slave outside.
 */
package olr_pkg;
    // ==========================================================
    // Byte addresses
    localparam logic [7:0] CUR_ADDR_LO = 8'h08;
    localparam logic [7:0] CUR_ADDR_HI = 8'h09;
    localparam logic [7:0] VTH_ADDR_LO = 8'h0A;
    localparam logic [7:0] VTH_ADDR_HI = 8'h0B;
    // ==========================================================
    // Field layout
    localparam int CUR_W = 7;
    localparam int VTH_W = 8;
    localparam logic [7:0] CUR_HI_RSVD = 8'h80;
    localparam logic [7:0] VTH_HI_RSVD = 8'hC0;
    localparam int VTH_LO_POS = 6;
    // ==========================================================
    // Reset values and scaling
    localparam logic [15:0] CUR_RESET = 16'h3C00;
    localparam logic [15:0] VTH_OFFSET_MV = 16'h0C80;
    localparam logic [15:0] VTH_DEFAULT_DROP_MV = 16'h0500;
    localparam logic [15:0] VTH_LSB_MV = 16'h0040;
    localparam logic [15:0] CUR_LSB_MA = 16'h0064;
endpackage

// >>> olr_limit_regs.sv
/*
 * Register pair holding the reverse-output current limit and the input
 * voltage threshold, with the regulation-mode compare.
 * Assumes a serial slave outside gives one-cycle byte write and read
 * strobes with an address, and an ADC gives input voltage in mV.
 */
// Summary of operation
// (R01) Current limit is seven binary-weighted bits, 100 mA to 6400 mA.
// (R02) Host keeps reserved upper bits zero; a one makes the write invalid.
// (R03) Unused low-byte bits are ignored on write.
// (R04) Current limit register reads 3C00h after reset.
// (R05) Threshold is eight bits split over both bytes, 64 mV to 8192 mV.
// (R06) Effective threshold is field value plus fixed 3.2 V offset.
// (R07) Input below threshold enters regulation mode and cuts charge current.
// (R08) Default threshold sits 1.28 V below no-load bus voltage.
// (R09) Host writes threshold as one 16-bit command, both byte addresses.
// (R10) Out-of-range or invalid writes are ignored; previous value kept.
// (R11) Reads return last accepted value, reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none
module olr_limit_regs
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Byte register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    // Analog side, millivolts
    input wire logic [15:0] VBUS_NOLOAD_MV,
    input wire logic [15:0] VIN_MV,
    // Limits and regulation
    output logic [15:0] REVERSE_OUTPUT_CURRENT_LIMIT_MA,
    output logic [15:0] INPUT_VOLTAGE_THRESHOLD_MV,
    output logic INPUT_VOLTAGE_REGULATION_MODE,
    output logic CHARGE_CURRENT_REDUCE
);
    import olr_pkg::*;

    // ==========================================================
    // State
    logic [CUR_W-1:0] cur_code;
    logic [CUR_W-1:0] next_cur_code;
    logic [VTH_W-1:0] vth_code;
    logic [VTH_W-1:0] next_vth_code;
    logic [1:0] vth_lo_pend;
    logic [1:0] next_vth_lo_pend;
    logic vth_default;
    logic next_vth_default;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic regmode;
    logic next_regmode;
    logic [15:0] vth_mv;
    logic [15:0] def_mv;
    logic [15:0] cur_ma;
    logic [15:0] code_mv;
    logic [15:0] cur_part [CUR_W];
    logic [15:0] vth_part [VTH_W];
    logic wr_cur_hi;
    logic wr_cur_lo;
    logic wr_vth_lo;
    logic wr_vth_hi;
    logic cur_hi_ok;
    logic vth_hi_ok;

    // ==========================================================
    // Write decode
    assign wr_cur_hi = WR_STB && (ADDR == CUR_ADDR_HI);
    assign wr_cur_lo = WR_STB && (ADDR == CUR_ADDR_LO);
    assign wr_vth_lo = WR_STB && (ADDR == VTH_ADDR_LO);
    assign wr_vth_hi = WR_STB && (ADDR == VTH_ADDR_HI);
    // A one in a reserved upper bit voids the whole write
    assign cur_hi_ok = ((WDATA & CUR_HI_RSVD) == 8'h00); // see (R10)
    assign vth_hi_ok = ((WDATA & VTH_HI_RSVD) == 8'h00); // see (R10)

    // ==========================================================
    // Current limit register
    always_comb begin
        next_cur_code = cur_code;
        if (wr_cur_hi && cur_hi_ok) begin
            next_cur_code = WDATA[CUR_W-1:0]; // see (R01)
        end
        // Low byte holds no field; its data is dropped
        if (wr_cur_lo) begin
            next_cur_code = cur_code; // see (R03)
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cur_code <= CUR_RESET[8 +: CUR_W]; // see (R04)
        end else begin
            cur_code <= next_cur_code;
        end
    end

    // ==========================================================
    // Threshold register
    always_comb begin
        next_vth_code = vth_code;
        next_vth_lo_pend = vth_lo_pend;
        next_vth_default = vth_default;
        if (wr_vth_lo) begin
            // Held until the upper byte completes the word
            next_vth_lo_pend = WDATA[7:VTH_LO_POS]; // see (R03)
        end
        if (wr_vth_hi && vth_hi_ok) begin
            next_vth_code = {WDATA[5:0], vth_lo_pend}; // see (R05)
            next_vth_default = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            vth_code <= 8'h00;
            vth_lo_pend <= 2'b00;
            vth_default <= 1'b1; // see (R08)
        end else begin
            vth_code <= next_vth_code;
            vth_lo_pend <= next_vth_lo_pend;
            vth_default <= next_vth_default;
        end
    end

    // ==========================================================
    // Binary weights, one term per field bit
    for (genvar i = 0; i < CUR_W; i++) begin : g_cur_bit
        assign cur_part[i] = cur_code[i]
            ? (CUR_LSB_MA << i) : 16'h0000; // see (R01)
    end

    for (genvar j = 0; j < VTH_W; j++) begin : g_vth_bit
        assign vth_part[j] = vth_code[j]
            ? (VTH_LSB_MV << j) : 16'h0000; // see (R05)
    end

    // ==========================================================
    // Field values in mA and mV
    always_comb begin
        cur_ma = 16'h0000;
        for (int k = 0; k < CUR_W; k++) begin
            cur_ma = cur_ma + cur_part[k];
        end
    end

    always_comb begin
        code_mv = 16'h0000;
        for (int k = 0; k < VTH_W; k++) begin
            code_mv = code_mv + vth_part[k];
        end
    end

    // ==========================================================
    // Threshold in mV
    always_comb begin
        // Default follows the bus, floored at the offset
        if (VBUS_NOLOAD_MV > VTH_OFFSET_MV + VTH_DEFAULT_DROP_MV) begin
            def_mv = VBUS_NOLOAD_MV - VTH_DEFAULT_DROP_MV; // see (R08)
        end else begin
            def_mv = VTH_OFFSET_MV;
        end
        if (vth_default) begin
            vth_mv = def_mv;
        end else begin
            vth_mv = VTH_OFFSET_MV + code_mv; // see (R06)
        end
    end

    // ==========================================================
    // Read data, held until the next read strobe
    always_comb begin
        next_rdata = rdata;
        if (RD_STB) begin
            unique case (ADDR)
                CUR_ADDR_HI: begin
                    next_rdata = {1'b0, cur_code}; // see (R11)
                end
                CUR_ADDR_LO: begin
                    next_rdata = 8'h00; // see (R11)
                end
                VTH_ADDR_HI: begin
                    next_rdata = {2'b00, vth_code[7:2]}; // see (R11)
                end
                VTH_ADDR_LO: begin
                    next_rdata = {vth_code[1:0], 6'h00}; // see (R11)
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Input-voltage regulation compare
    always_comb begin
        // Input below the threshold sets regulation mode
        next_regmode = (VIN_MV < vth_mv); // see (R07)
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            regmode <= 1'b0;
        end else begin
            regmode <= next_regmode;
        end
    end

    // ==========================================================
    // Outputs
    assign RDATA = rdata;
    assign REVERSE_OUTPUT_CURRENT_LIMIT_MA = cur_ma; // see (R01)
    assign INPUT_VOLTAGE_THRESHOLD_MV = vth_mv;
    assign INPUT_VOLTAGE_REGULATION_MODE = regmode;
    // Charge current is cut for as long as regulation holds
    assign CHARGE_CURRENT_REDUCE = regmode; // see (R07)
endmodule // olr_limit_regs
`default_nettype wire

// >>> olr_limit_regs_sva.sv
/* Checks on the register pair ports; assumes one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module olr_limit_regs_sva (
    // Watched ports
    input wire logic CLK, RST, WR_STB, RD_STB, CHARGE_CURRENT_REDUCE,
    input wire logic INPUT_VOLTAGE_REGULATION_MODE,
    input wire logic [7:0] ADDR, WDATA, RDATA,
    input wire logic [15:0] VIN_MV, INPUT_VOLTAGE_THRESHOLD_MV,
    input wire logic [15:0] REVERSE_OUTPUT_CURRENT_LIMIT_MA
);
    wire logic [15:0] lim = REVERSE_OUTPUT_CURRENT_LIMIT_MA;
    wire logic low = VIN_MV < INPUT_VOLTAGE_THRESHOLD_MV;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    chk_cur_scale: assert property (WR_STB && ADDR == 8'h09 && !WDATA[7]
        |=> lim == $past(WDATA[6:0]) * 16'h64) else $error("scale");
    chk_cur_rsvd: assert property (WR_STB && ADDR == 8'h09 && WDATA[7]
        |=> $stable(lim)) else $error("reserved");
    chk_low_byte: assert property (WR_STB && ADDR == 8'h08
        |=> $stable(lim)) else $error("low byte");
    chk_vth_pair: assert property (WR_STB && ADDR == 8'h0A ##1
        WR_STB && ADDR == 8'h0B && WDATA[7:6] == 2'h0 |=>
        INPUT_VOLTAGE_THRESHOLD_MV == 16'hC80 +
        {$past(WDATA[5:0]), $past(WDATA[7:6], 2), 6'h0}) else $error("vth");
    chk_reg_mode: assert property (!$past(RST) |->
        INPUT_VOLTAGE_REGULATION_MODE == $past(low)) else $error("mode");
    chk_cut_same: assert property (CHARGE_CURRENT_REDUCE ==
        INPUT_VOLTAGE_REGULATION_MODE) else $error("cut");
    chk_rd_hold: assert property (!RD_STB |=> $stable(RDATA))
        else $error("hold");
    chk_rd_cur: assert property (RD_STB && ADDR == 8'h09 |=>
        RDATA == 8'($past(lim) / 16'h64)) else $error("read");
endmodule // olr_limit_regs_sva
bind olr_limit_regs olr_limit_regs_sva u_olr_limit_regs_sva (.*);
`default_nettype wire

// >>> olr_host_model.sv
/* Host issuing byte strobes; assumes rising-edge sampling. */
`timescale 1ns/1ps
`default_nettype none
module olr_host_model (
    // Byte register port
    input wire logic CLK,
    output logic [7:0] ADDR, WDATA,
    output logic WR_STB, RD_STB
);
    initial {WR_STB, RD_STB, ADDR, WDATA} = 18'h0;
    task automatic put(input logic [17:0] v);
        @(negedge CLK) {WR_STB, RD_STB, ADDR, WDATA} = v;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        put({2'h2, a, v[7:0]});
        put({2'h2, a + 8'h01, v[15:8]});
        put({2'h0, ~a, ~v[15:8]});
    endtask
    task automatic rd8(input logic [7:0] a);
        put({2'h1, a, 8'h00});
        put({2'h0, ~a, 8'hFF});
    endtask
endmodule // olr_host_model
`default_nettype wire

// >>> olr_limit_regs_test.sv
/* Bench for the register pair; assumes host model and checker. */
`timescale 1ns/1ps
`default_nettype none
module olr_limit_regs_test;
    logic CLK = 1'b0, RST = 1'b1, WR_STB, RD_STB, CHARGE_CURRENT_REDUCE;
    logic INPUT_VOLTAGE_REGULATION_MODE;
    logic [7:0] ADDR, WDATA, RDATA;
    logic [15:0] VBUS_NOLOAD_MV = 16'h4E20, VIN_MV = 16'hFFFF;
    logic [15:0] REVERSE_OUTPUT_CURRENT_LIMIT_MA, INPUT_VOLTAGE_THRESHOLD_MV;
    int miscompares = 0, checks_done = 0, cyc = 0;
    olr_limit_regs u_olr_limit_regs (.*);
    olr_host_model u_olr_host_model (.*);
    always #50 CLK = ~CLK;
    always @(posedge CLK) if (++cyc == 300) summarize(1);
    task automatic chk(input logic [15:0] g, e);
        checks_done++;
        if (g !== e) miscompares++;
        if (g !== e) $display("[FAIL] %0t got %h", $time, g);
    endtask
    task automatic summarize(input int late);
        miscompares += late;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200 RST = 1'b0;
        chk(REVERSE_OUTPUT_CURRENT_LIMIT_MA, 16'h1770);
        u_olr_host_model.rd8(8'h09);
        chk(RDATA, 8'h3C);
        chk(INPUT_VOLTAGE_THRESHOLD_MV, 16'h4920);
        chk(INPUT_VOLTAGE_REGULATION_MODE, 1'b0);
        u_olr_host_model.wr16(8'h08, 16'h7FFF);
        chk(REVERSE_OUTPUT_CURRENT_LIMIT_MA, 16'h319C);
        u_olr_host_model.wr16(8'h08, 16'h8155);
        u_olr_host_model.rd8(8'h09);
        chk(RDATA, 8'h7F);
        u_olr_host_model.rd8(8'h08);
        chk(RDATA, 8'h00);
        u_olr_host_model.wr16(8'h0A, 16'h3FC0);
        VIN_MV = 16'h4C3F;
        u_olr_host_model.rd8(8'h0A);
        chk(RDATA, 8'hC0);
        chk(INPUT_VOLTAGE_THRESHOLD_MV, 16'h4C40);
        chk(INPUT_VOLTAGE_REGULATION_MODE, 1'b1);
        chk(CHARGE_CURRENT_REDUCE, 1'b1);
        u_olr_host_model.wr16(8'h0A, 16'h4000);
        u_olr_host_model.rd8(8'h0B);
        chk(RDATA, 8'h3F);
        u_olr_host_model.wr16(8'h0A, 16'h0000);
        chk(INPUT_VOLTAGE_THRESHOLD_MV, 16'h0C80);
        $display("limit tests done");
        summarize(0);
    end
endmodule // olr_limit_regs_test
`default_nettype wire
